// ===== verilog/pmbus_fault_pkg.sv
package pmbus_fault_pkg;

  // ****************************************
  // Command codes of the held settings
  // ****************************************
  localparam logic [7:0] CMD_UT_ACT = 8'h54;
  localparam logic [7:0] CMD_OV_THR = 8'h55;
  localparam logic [7:0] CMD_OV_ACT = 8'h56;
  localparam logic [7:0] CMD_UNIT = 8'hc8;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [15:0] OV_THR_RST = 16'h7bff;
  localparam logic [7:0] OV_ACT_RST = 8'hc0;
  localparam logic [7:0] UT_ACT_RST = 8'hc0;
  localparam logic [15:0] UNIT_RST = 16'h0001;

  // ****************************************
  // Field positions of a response setting
  // ****************************************
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int MULT_HI = 2;
  localparam int MULT_LO = 0;

  // Response and retry codes
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RUN = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ****************************************
  // Time base: delay unit register counts microseconds
  // ****************************************
  localparam int CLK_NS = 25;
  localparam int UNIT_BASE_NS = 1000;
  localparam int UNIT_BASE_CYC = (UNIT_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] UNIT_BASE_LAST = 6'(UNIT_BASE_CYC - 1);

  // Fault handling states
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_RUN_DELAY = 3'b001,
    ST_OFF_WAIT = 3'b010,
    ST_TRY = 3'b011,
    ST_LATCHED = 3'b100
  } fault_state_t;

endpackage

// ===== verilog/linear_above.sv
`timescale 1ns/1ps
`default_nettype none
module linear_above (
  input wire logic [15:0] sample_i,
  input wire logic [15:0] limit_i,
  output logic above_o
);

  // ****************************************
  // Linear format to common fixed point
  // ****************************************
  // Exponent plus 16 is the exponent with its sign bit flipped
  function automatic logic signed [42:0] to_fixed(input logic [15:0] v);
    logic [4:0] shamt;
    logic signed [42:0] wide;
    shamt = {~v[15], v[14:11]};
    wide = $signed({{32{v[10]}}, v[10:0]});
    to_fixed = wide <<< shamt;
  endfunction

  // Strictly above the threshold counts as a fault
  assign above_o = to_fixed(sample_i) > to_fixed(limit_i);

endmodule
`default_nettype wire

// ===== verilog/delay_unit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module delay_unit_timer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [2:0] mult_code_i,
  input wire logic [15:0] unit_len_i,
  output logic expire_o
);
  import pmbus_fault_pkg::*;

  logic run_r;
  logic [5:0] base_cnt_r;
  logic [15:0] unit_cnt_r;
  logic [7:0] mult_cnt_r;
  logic [7:0] target;
  logic base_tick;
  logic unit_done;
  logic last_unit;

  // ****************************************
  // Decode and tick terms
  // ****************************************
  assign target = 8'h01 << mult_code_i;
  assign base_tick = run_r && (base_cnt_r == UNIT_BASE_LAST);
  // A unit length of zero acts as one
  assign unit_done = base_tick && (({1'b0, unit_cnt_r} + 17'h1) >= {1'b0, unit_len_i});
  assign last_unit = unit_done && ((mult_cnt_r + 8'h1) == target);

  // Single timer, restarted on every start
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || start_i) begin
      base_cnt_r <= 6'h00;
      unit_cnt_r <= 16'h0000;
      mult_cnt_r <= 8'h00;
    end else if (run_r) begin
      base_cnt_r <= base_tick ? 6'h00 : base_cnt_r + 6'h01;
      if (unit_done) begin
        unit_cnt_r <= 16'h0000;
        mult_cnt_r <= mult_cnt_r + 8'h01;
      end else if (base_tick) begin
        unit_cnt_r <= unit_cnt_r + 16'h0001;
      end
    end
  end

  // Run flag and expiry pulse
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_r <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= !start_i && run_r && last_unit;
      if (start_i) begin
        run_r <= 1'b1;
      end else if (last_unit) begin
        run_r <= 1'b0;
      end
    end
  end

  expire_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    expire_o |-> ($past(mult_cnt_r) + 8'h1) == $past(target))
    else $error("expiry at wrong unit count");

  restart_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    start_i |=> (mult_cnt_r == 8'h00) && run_r && !expire_o)
    else $error("timer not restarted");

endmodule
`default_nettype wire

// ===== verilog/pmbus_fault_retry_response.sv
`timescale 1ns/1ps
`default_nettype none
module pmbus_fault_retry_response (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_cmd_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [15:0] vin_sample_i,
  input wire logic vin_valid_i,
  input wire logic ctrl_pin_i,
  input wire logic op_on_i,
  input wire logic clear_faults_i,
  input wire logic status_clear_i,
  input wire logic other_fault_off_i,
  output logic out_enable_o,
  output logic vin_ov_status_o,
  output pmbus_fault_pkg::fault_state_t state_o
);
  import pmbus_fault_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] ov_thr_r;
  logic [7:0] ov_act_r;
  logic [7:0] ut_act_r;
  logic [15:0] unit_len_r;
  logic ctrl_s1_r;
  logic ctrl_s2_r;
  logic ctrl_s3_r;
  logic ctrl_on_r;
  logic fault_now_r;
  logic off_seen_r;
  logic [2:0] tries_r;
  logic [2:0] tries_nxt;
  fault_state_t state_r;
  fault_state_t state_nxt;
  logic over_w;
  logic cmd_on;
  logic stop_retry;
  logic clear_any;
  logic timer_start;
  logic expire_w;
  logic out_en_nxt;
  logic [1:0] resp_fld;
  logic [2:0] retry_fld;
  logic limit_hit;

  // ****************************************
  // Register port
  // ****************************************
  // Setting writes, narrow settings take the low byte
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ov_thr_r <= OV_THR_RST;
      ov_act_r <= OV_ACT_RST;
      ut_act_r <= UT_ACT_RST;
      unit_len_r <= UNIT_RST;
    end else if (reg_wr_i) begin
      unique case (reg_cmd_i)
        CMD_OV_THR: ov_thr_r <= reg_wdata_i;
        CMD_OV_ACT: ov_act_r <= reg_wdata_i[7:0];
        CMD_UT_ACT: ut_act_r <= reg_wdata_i[7:0];
        CMD_UNIT: unit_len_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Read data, unknown codes read as zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        unique case (reg_cmd_i)
          CMD_OV_THR: reg_rdata_o <= ov_thr_r;
          CMD_OV_ACT: reg_rdata_o <= {8'h00, ov_act_r};
          CMD_UT_ACT: reg_rdata_o <= {8'h00, ut_act_r};
          CMD_UNIT: reg_rdata_o <= unit_len_r;
          default: reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // Fields of the response setting
  assign resp_fld = ov_act_r[RESP_HI:RESP_LO];
  assign retry_fld = ov_act_r[RETRY_HI:RETRY_LO];

  // ****************************************
  // Control pin and on command
  // ****************************************
  // Pin synchroniser, level taken once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_s1_r <= 1'b0;
      ctrl_s2_r <= 1'b0;
      ctrl_s3_r <= 1'b0;
      ctrl_on_r <= 1'b0;
    end else begin
      ctrl_s1_r <= ctrl_pin_i;
      ctrl_s2_r <= ctrl_s1_r;
      ctrl_s3_r <= ctrl_s2_r;
      if (ctrl_s2_r == ctrl_s3_r) begin
        ctrl_on_r <= ctrl_s3_r;
      end
    end
  end

  assign cmd_on = ctrl_on_r && op_on_i;
  assign stop_retry = !cmd_on || other_fault_off_i;

  // ****************************************
  // Fault detection and status
  // ****************************************
  linear_above u_cmp (
    .sample_i(vin_sample_i),
    .limit_i(ov_thr_r),
    .above_o(over_w)
  );

  // Fault level follows each valid sample
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fault_now_r <= 1'b0;
    end else if (vin_valid_i) begin
      fault_now_r <= over_w;
    end
  end

  // Sticky status bit, a new fault wins over a clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      vin_ov_status_o <= 1'b0;
    end else if (fault_now_r) begin
      vin_ov_status_o <= 1'b1;
    end else if (status_clear_i || clear_faults_i) begin
      vin_ov_status_o <= 1'b0;
    end
  end

  // Off seen while latched, armed for the off then on clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_r != ST_LATCHED) begin
      off_seen_r <= 1'b0;
    end else if (!cmd_on) begin
      off_seen_r <= 1'b1;
    end
  end

  assign clear_any = clear_faults_i || status_clear_i || (off_seen_r && cmd_on);
  assign limit_hit = (retry_fld != RETRY_FOREVER) && (tries_r >= retry_fld);

  // ****************************************
  // Delay timer
  // ****************************************
  delay_unit_timer u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(timer_start),
    .mult_code_i(ov_act_r[MULT_HI:MULT_LO]),
    .unit_len_i(unit_len_r),
    .expire_o(expire_w)
  );

  // ****************************************
  // Response state machine
  // ****************************************
  // Next state, timer restarts and attempt count
  always_comb begin
    state_nxt = state_r;
    timer_start = 1'b0;
    tries_nxt = tries_r;
    unique case (state_r)
      ST_NORMAL: begin
        tries_nxt = 3'h0;
        if (fault_now_r && !stop_retry) begin
          unique case (resp_fld)
            RESP_IGNORE: ;
            RESP_RUN: begin
              state_nxt = ST_RUN_DELAY;
              timer_start = 1'b1;
            end
            RESP_RETRY: begin
              if (retry_fld == RETRY_NONE) begin
                state_nxt = ST_LATCHED;
              end else begin
                state_nxt = ST_OFF_WAIT;
                timer_start = 1'b1;
              end
            end
            RESP_LATCH: state_nxt = ST_LATCHED;
          endcase
        end
      end
      ST_RUN_DELAY: begin
        if (stop_retry) begin
          state_nxt = ST_NORMAL;
        end else if (expire_w) begin
          if (!fault_now_r) begin
            state_nxt = ST_NORMAL;
          end else if (retry_fld == RETRY_NONE) begin
            state_nxt = ST_LATCHED;
          end else begin
            state_nxt = ST_OFF_WAIT;
            timer_start = 1'b1;
          end
        end
      end
      ST_OFF_WAIT: begin
        if (stop_retry) begin
          state_nxt = ST_NORMAL;
        end else if (expire_w) begin
          state_nxt = ST_TRY;
          timer_start = 1'b1;
          if (tries_r != RETRY_FOREVER) begin
            tries_nxt = tries_r + 3'h1;
          end
        end
      end
      ST_TRY: begin
        if (stop_retry) begin
          state_nxt = ST_NORMAL;
        end else if (fault_now_r) begin
          // Timer runs on for even spacing, rearmed if it ends in this cycle
          state_nxt = limit_hit ? ST_LATCHED : ST_OFF_WAIT;
          timer_start = expire_w;
        end else if (expire_w) begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_LATCHED: begin
        if (clear_any) begin
          state_nxt = ST_NORMAL;
        end
      end
      default: state_nxt = ST_NORMAL;
    endcase
  end

  // Output allowed in running states only
  assign out_en_nxt = cmd_on && !other_fault_off_i &&
    (state_nxt == ST_NORMAL || state_nxt == ST_RUN_DELAY || state_nxt == ST_TRY);

  // State, attempt count and output enable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_NORMAL;
      tries_r <= 3'h0;
      out_enable_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tries_r <= tries_nxt;
      out_enable_o <= out_en_nxt;
    end
  end

  assign state_o = state_r;

  // ****************************************
  // Checks
  // ****************************************
  threshold_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_cmd_i == CMD_OV_THR) |=> ov_thr_r == $past(reg_wdata_i))
    else $error("threshold not stored");

  ignore_runs_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_NORMAL && fault_now_r && cmd_on && !other_fault_off_i
      && resp_fld == RESP_IGNORE) |=> out_enable_o && state_r == ST_NORMAL)
    else $error("ignored fault interrupted output");

  delay_running_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_RUN_DELAY && cmd_on && !other_fault_off_i && !expire_w)
      |=> out_enable_o)
    else $error("output off during run delay");

  disable_now_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_NORMAL && fault_now_r && cmd_on && resp_fld == RESP_RETRY)
      |=> !out_enable_o ##1 !out_enable_o)
    else $error("output not disabled at once");

  latch_holds_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_LATCHED && !clear_any) |=> state_r == ST_LATCHED && !out_enable_o)
    else $error("latched fault left without clear");

  clear_exits_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_LATCHED && (clear_faults_i || status_clear_i)) |=> state_r == ST_NORMAL)
    else $error("clear did not release latch");

  off_on_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_LATCHED && off_seen_r && cmd_on) |=> state_r == ST_NORMAL)
    else $error("off then on did not release latch");

  no_retry_latch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_NORMAL && fault_now_r && cmd_on && resp_fld == RESP_RETRY
      && retry_fld == RETRY_NONE && !other_fault_off_i) |=> state_r == ST_LATCHED)
    else $error("zero retries did not latch");

  attempts_spent_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_TRY && cmd_on && !other_fault_off_i && fault_now_r
      && retry_fld != RETRY_FOREVER && tries_r == retry_fld) |=> state_r == ST_LATCHED)
    else $error("spent retries did not latch");

  attempt_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_TRY && retry_fld != RETRY_FOREVER) |-> tries_r <= retry_fld)
    else $error("more attempts than programmed");

  forever_retry_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_TRY && cmd_on && !other_fault_off_i && fault_now_r
      && retry_fld == RETRY_FOREVER) |=> state_r == ST_OFF_WAIT)
    else $error("endless retry stopped");

endmodule
`default_nettype wire

// ===== verif/pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Management bus host issuing setting accesses
// ****************************************
module pmbus_host_model (
  input wire logic clk_i,
  output logic [7:0] reg_cmd_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_wdata_o
);
  // Quiet bus from time zero
  initial begin
    reg_cmd_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // One access held over one rising edge, lines scrambled afterwards
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clk_i);
    reg_cmd_o = cmd;
    reg_wdata_o = data;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_cmd_o = ~cmd;
    reg_wdata_o = ~data;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pmbus_fault_pkg::*;
  localparam logic [15:0] THR = 16'h0064;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_cmd_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [15:0] reg_wdata_i;
  logic [15:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [15:0] vin_sample_i = 16'h0000;
  logic vin_valid_i = 1'b1;
  logic ctrl_pin_i = 1'b1;
  logic op_on_i = 1'b1;
  logic clear_faults_i = 1'b0;
  logic status_clear_i = 1'b0;
  logic other_fault_off_i = 1'b0;
  logic out_enable_o;
  logic vin_ov_status_o;
  fault_state_t state_o;
  logic [15:0] exp_q[$];
  logic [2:0] rn[4] = '{3'h1, 3'h2, 3'h6, 3'h1};
  logic [2:0] rm[4] = '{3'h0, 3'h1, 3'h0, 3'h7};
  logic [15:0] ru[4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0001};
  int error_cnt = 0;
  int compares = 0;
  int t;
  int u;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  pmbus_host_model host (
    .clk_i(clk_i),
    .reg_cmd_o(reg_cmd_i),
    .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i),
    .reg_wdata_o(reg_wdata_i)
  );

  pmbus_fault_retry_response DUT (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .reg_cmd_i(reg_cmd_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .vin_sample_i(vin_sample_i),
    .vin_valid_i(vin_valid_i),
    .ctrl_pin_i(ctrl_pin_i),
    .op_on_i(op_on_i),
    .clear_faults_i(clear_faults_i),
    .status_clear_i(status_clear_i),
    .other_fault_off_i(other_fault_off_i),
    .out_enable_o(out_enable_o),
    .vin_ov_status_o(vin_ov_status_o),
    .state_o(state_o)
  );

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Read answers taken off the queue in order
  always @(negedge clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() > 0) begin
        check(reg_rdata_o, exp_q.pop_front());
      end else begin
        check(1'b1, 1'b0);
      end
    end
  end

  // Watchdog
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end

  // ****************************************
  // Stimulus helpers
  // ****************************************
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.access(1'b1, c, d);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    host.access(1'b0, c, 16'h0000);
  endtask

  task automatic vin(input logic over);
    @(negedge clk_i);
    vin_sample_i = over ? 16'(101 + $urandom % 900) : 16'($urandom % 100);
  endtask

  task automatic stay(input logic v, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge clk_i);
      bad = bad | (out_enable_o !== v);
    end
    check(bad, 1'b0);
  endtask

  task automatic wait_out(input logic v, input int lim, output int n);
    n = 0;
    while (out_enable_o !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    check(out_enable_o, v);
  endtask

  // Clearing: 0 command, 1 status bit, 2 operation off/on, 3 pin off/on
  task automatic clr(input int k);
    @(negedge clk_i);
    clear_faults_i = (k == 0);
    status_clear_i = (k == 1);
    op_on_i = (k != 2);
    ctrl_pin_i = (k != 3);
    @(negedge clk_i);
    clear_faults_i = 1'b0;
    status_clear_i = 1'b0;
    repeat (5) @(negedge clk_i);
    op_on_i = 1'b1;
    ctrl_pin_i = 1'b1;
  endtask

  // Held fault: count attempts and their spacing, then final latch
  task automatic retry_case(input logic [2:0] n, input logic [2:0] m, input logic [15:0] un);
    int e;
    int a;
    int b;
    e = (40 << m) * un;
    wr(CMD_UNIT, un);
    wr(CMD_OV_ACT, {8'h00, RESP_RETRY, n, m});
    vin(1'b1);
    wait_out(1'b0, 6, a);
    a = 0;
    repeat (n) begin
      wait_out(1'b1, e + 6, b);
      check((a + b >= e - 3) && (a + b <= e + 2), 1'b1);
      wait_out(1'b0, 6, a);
    end
    stay(1'b0, e + 10);
    check(state_o, ST_LATCHED);
    vin(1'b0);
    clr(0);
    wait_out(1'b1, 12, a);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h8b81));
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd(CMD_OV_THR, OV_THR_RST);
    rd(CMD_OV_ACT, {8'h00, OV_ACT_RST});
    rd(CMD_UT_ACT, {8'h00, UT_ACT_RST});
    rd(CMD_UNIT, UNIT_RST);
    u = $urandom;
    // Non-negative threshold so the idle zero sample stays below it
    u[10] = 1'b0;
    wr(CMD_OV_THR, u[15:0]);
    wr(8'h57, 16'h1234);
    rd(CMD_OV_THR, u[15:0]);
    rd(8'h57, 16'h0000);
    wr(CMD_OV_ACT, 16'hff12);
    rd(CMD_OV_ACT, 16'h0012);
    wr(CMD_OV_THR, THR);
    repeat (4) @(negedge clk_i);
    // Ignore response keeps the output up
    wr(CMD_OV_ACT, {8'h00, RESP_IGNORE, 6'h3f});
    vin(1'b1);
    stay(1'b1, 100);
    check(state_o, ST_NORMAL);
    check(vin_ov_status_o, 1'b1);
    vin(1'b0);
    // Latch off, threshold boundary, every way of clearing
    wr(CMD_OV_ACT, {8'h00, RESP_LATCH, 6'h00});
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_i);
      vin_sample_i = THR;
      stay(1'b1, 10);
      @(negedge clk_i);
      vin_sample_i = THR + 16'h0001;
      wait_out(1'b0, 6, t);
      check(state_o, ST_LATCHED);
      vin(1'b0);
      stay(1'b0, 30);
      clr(k);
      wait_out(1'b1, 12, t);
      if (k == 1) check(vin_ov_status_o, 1'b0);
    end
    // Disable with no retry
    wr(CMD_OV_ACT, {8'h00, RESP_RETRY, RETRY_NONE, 3'h0});
    vin(1'b1);
    wait_out(1'b0, 6, t);
    vin(1'b0);
    stay(1'b0, 200);
    clr(0);
    wait_out(1'b1, 12, t);
    // Keep running for the delay, then latch; short fault passes
    wr(CMD_OV_ACT, {8'h00, RESP_RUN, RETRY_NONE, 3'h1});
    vin(1'b1);
    stay(1'b1, 70);
    check(state_o, ST_RUN_DELAY);
    wait_out(1'b0, 20, t);
    check(state_o, ST_LATCHED);
    vin(1'b0);
    clr(0);
    wait_out(1'b1, 12, t);
    vin(1'b1);
    repeat (20) @(negedge clk_i);
    vin(1'b0);
    stay(1'b1, 150);
    check(state_o, ST_NORMAL);
    // Limited retries with several multipliers and units
    foreach (rn[i]) retry_case(rn[i], rm[i], ru[i]);
    // Endless retries stopped by another shutdown
    wr(CMD_OV_ACT, {8'h00, RESP_RETRY, RETRY_FOREVER, 3'h0});
    vin(1'b1);
    wait_out(1'b0, 6, t);
    repeat (9) begin
      wait_out(1'b1, 50, t);
      wait_out(1'b0, 6, t);
    end
    check(state_o == ST_LATCHED, 1'b0);
    @(negedge clk_i);
    other_fault_off_i = 1'b1;
    stay(1'b0, 100);
    check(state_o, ST_NORMAL);
    vin(1'b0);
    // Let the fault level fall before the other shutdown lifts
    repeat (2) @(negedge clk_i);
    other_fault_off_i = 1'b0;
    wait_out(1'b1, 12, t);
    repeat (4) @(negedge clk_i);
    check(exp_q.size() == 0, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
